// ---- src/dbss_pkg.sv ----
// Shared constants and types for the single-step and low-power control
// of the background debug unit.
// Assumes a 25 MHz target clock and a decoded command stream.
package dbss_pkg;
   // Target clock rate and the length of one acknowledge pulse
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned ACK_PULSE_CYC = 16;
   localparam int unsigned ACK_CNT_W = 5;
   localparam int unsigned PC_W = 16;
   localparam logic [15:0] PC_RST = 16'h0000;

   // Decoded debug commands arriving from the serial link
   typedef enum logic [2:0] {
      CMD_STEP      = 3'h0, // single_step_command
      CMD_GO        = 3'h1, // Resume user code
      CMD_FORCE_ACT = 3'h2, // Force entry into debug active mode
      CMD_ACK_EN    = 3'h3, // Enable handshake
      CMD_ACK_DIS   = 3'h4, // Disable handshake
      CMD_HW        = 3'h5, // Hardware memory access command
      CMD_FW        = 3'h6  // Firmware command, needs active mode
   } dbss_cmd_type;

   // Sequencer states, one-hot
   typedef enum logic [3:0] {
      ST_ACTIVE = 4'h1, // Core halted in debug firmware
      ST_STEP   = 4'h2, // Core executing one step
      ST_LOWPWR = 4'h4, // Stepped stop or wait, core asleep
      ST_RUN    = 4'h8  // User code running freely
   } dbss_state_type;
endpackage

// ---- src/dbss_ack_if.sv ----
// Carrier between the step sequencer and the acknowledge generator.
// Assumes both ends share clk_sys_in.
`timescale 1ns/1ps
`default_nettype none
interface dbss_ack_if;
   logic ack_req;   // One-cycle request for an acknowledge pulse
   logic hs_set;    // Handshake enable command taken
   logic hs_clr;    // Handshake disable command taken
   logic sys_stop;  // System stop level
   logic hs_en;     // Current handshake enable state
   logic ack_busy;  // Pulse in progress

   modport ctrl (output ack_req, output hs_set, output hs_clr,
                 output sys_stop, input hs_en, input ack_busy);
   modport gen (input ack_req, input hs_set, input hs_clr,
                input sys_stop, output hs_en, output ack_busy);
endinterface
`default_nettype wire

// ---- src/dbss_ack_gen.sv ----
// Handshake state and acknowledge pulse generator.
// Assumes requests come as single-cycle pulses from the sequencer.
`timescale 1ns/1ps
`default_nettype none
module dbss_ack_gen
   import dbss_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   dbss_ack_if.gen ack_if,
   output logic ack_pulse_out
);
   logic hs_en_q, hs_en_d;
   logic [ACK_CNT_W-1:0] cnt_q, cnt_d;
   logic ack_q, ack_d;

   // Handshake state and pulse timer
   always_comb
   begin
      hs_en_d = hs_en_q;
      if (ack_if.hs_set)
         hs_en_d = 1'b1;
      else if (ack_if.hs_clr)
         hs_en_d = 1'b0;
      if (ack_if.sys_stop)
         hs_en_d = 1'b0;
      cnt_d = cnt_q;
      ack_d = ack_q;
      if (ack_q)
      begin
         cnt_d = cnt_q - ACK_CNT_W'(1);
         if (cnt_q == ACK_CNT_W'(1))
            ack_d = 1'b0;
      end
      else if (ack_if.ack_req && hs_en_q && !ack_if.sys_stop)
      begin
         ack_d = 1'b1;
         cnt_d = ACK_CNT_W'(ACK_PULSE_CYC);
      end
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         hs_en_q <= 1'b0;
         cnt_q <= '0;
         ack_q <= 1'b0;
      end
      else
      begin
         hs_en_q <= hs_en_d;
         cnt_q <= cnt_d;
         ack_q <= ack_d;
      end
   end

   assign ack_if.hs_en = hs_en_q;
   assign ack_if.ack_busy = ack_q;
   assign ack_pulse_out = ack_q;

   // Handshake never survives system stop
   property p_hs_clear_on_stop;
      @(posedge clk_sys_in) disable iff (rst_in)
      ack_if.sys_stop |=> !hs_en_q;
   endproperty
   a_hs_clear_on_stop: assert property (p_hs_clear_on_stop)
      else $error("handshake kept through system stop");

   // Cycles the pulse has stood so far, kept only for the length check
   logic [ACK_CNT_W-1:0] len_q, len_d;

   // Restarts at zero whenever the pulse is low
   always_comb
   begin
      len_d = '0;
      if (ack_q)
         len_d = len_q + ACK_CNT_W'(1);
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
         len_q <= '0;
      else
         len_q <= len_d;
   end

   // Pulse lasts exactly the set number of cycles
   property p_ack_len;
      @(posedge clk_sys_in) disable iff (rst_in)
      $fell(ack_q) |-> len_q == ACK_CNT_W'(ACK_PULSE_CYC);
   endproperty
   a_ack_len: assert property (p_ack_len)
      else $error("acknowledge pulse length wrong");
endmodule
`default_nettype wire

// ---- src/dbss_step_ctrl.sv ----
// Single-step and low-power command sequencer of the debug unit.
// Assumes a decoded command stream and a core that answers step requests.
`timescale 1ns/1ps
`default_nettype none
module dbss_step_ctrl
   import dbss_pkg::*;
#(
   parameter int unsigned PC_WIDTH = PC_W
)
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic cmd_valid_in,
   input wire dbss_pkg::dbss_cmd_type cmd_kind_in,
   input wire logic irq_pending_in,
   input wire logic [PC_WIDTH-1:0] irq_vector_in,
   input wire logic [PC_WIDTH-1:0] core_pc_in,
   input wire logic core_step_done_in,
   input wire logic core_lowpwr_in,
   input wire logic system_stop_in,
   input wire logic soft_break_instr_in,
   output logic core_exec_one_out,
   output logic core_stack_irq_out,
   output logic core_go_out,
   output logic debug_active_out,
   output logic periph_free_run_out,
   output logic [PC_WIDTH-1:0] saved_pc_out,
   output logic cmd_done_out,
   output logic cmd_refused_out,
   output logic hs_enabled_out,
   output logic soft_break_step_out,
   output logic ack_pulse_out
);
   import dbss_pkg::*;
   dbss_ack_if ack_if ();

   dbss_state_type state_q, state_d;
   logic [PC_WIDTH-1:0] pc_q, pc_d;
   logic stacking_q, stacking_d;
   logic exec_one_q, exec_one_d;
   logic stack_q, stack_d;
   logic go_q, go_d;
   logic done_q, done_d;
   logic refused_q, refused_d;
   logic sbrk_q, sbrk_d;
   logic free_run_q, free_run_d;
   logic ack_req;
   logic hs_set;
   logic hs_clr;
   logic accept;

   // Which commands are taken in which state
   always_comb
   begin
      accept = 1'b0;
      if (cmd_valid_in && !system_stop_in)
      begin
         unique case (state_q)
            ST_ACTIVE:
               accept = 1'b1;
            ST_STEP, ST_RUN:
               accept = (cmd_kind_in != CMD_FW) &&
                        (cmd_kind_in != CMD_STEP) &&
                        (cmd_kind_in != CMD_GO);
            ST_LOWPWR:
               accept = (cmd_kind_in == CMD_HW) ||
                        (cmd_kind_in == CMD_ACK_EN) ||
                        (cmd_kind_in == CMD_ACK_DIS);
         endcase
         // Cannot break into a core that is still mid-step
         if (state_q == ST_STEP && cmd_kind_in == CMD_FORCE_ACT)
            accept = 1'b0;
      end
   end

   // Sequencer next state
   always_comb
   begin
      state_d = state_q;
      pc_d = pc_q;
      stacking_d = stacking_q;
      exec_one_d = 1'b0;
      stack_d = 1'b0;
      go_d = 1'b0;
      done_d = 1'b0;
      refused_d = cmd_valid_in && !accept;
      sbrk_d = 1'b0;
      ack_req = 1'b0;
      hs_set = accept && (cmd_kind_in == CMD_ACK_EN);
      hs_clr = accept && (cmd_kind_in == CMD_ACK_DIS);
      // Peripherals are never frozen by stepping
      free_run_d = 1'b1;
      if (accept && cmd_kind_in != CMD_STEP)
      begin
         done_d = 1'b1;
         ack_req = 1'b1;
      end
      unique case (state_q)
         ST_ACTIVE:
         begin
            if (accept && cmd_kind_in == CMD_STEP)
            begin
               state_d = ST_STEP;
               stacking_d = irq_pending_in;
               stack_d = irq_pending_in;
               exec_one_d = !irq_pending_in;
               // Flag a step over the soft break so the host is warned
               sbrk_d = soft_break_instr_in && !irq_pending_in;
            end
            else if (accept && cmd_kind_in == CMD_GO)
            begin
               state_d = ST_RUN;
               go_d = 1'b1;
            end
         end
         ST_STEP:
         begin
            if (core_lowpwr_in)
               state_d = ST_LOWPWR;
            else if (core_step_done_in)
            begin
               state_d = ST_ACTIVE;
               done_d = 1'b1;
               ack_req = 1'b1;
               if (stacking_q)
                  pc_d = irq_vector_in;
               else
                  pc_d = core_pc_in;
            end
         end
         ST_LOWPWR:
         begin
            if (!core_lowpwr_in)
            begin
               // Step finishes silently on wake
               state_d = ST_ACTIVE;
               pc_d = irq_vector_in;
               done_d = 1'b1;
               // A command taken in this same cycle still gets its ack
               ack_req = accept && cmd_kind_in != CMD_STEP;
            end
         end
         ST_RUN:
         begin
            if (accept && cmd_kind_in == CMD_FORCE_ACT)
            begin
               state_d = ST_ACTIVE;
               pc_d = core_pc_in;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         state_q <= ST_ACTIVE;
         pc_q <= PC_WIDTH'(PC_RST);
         stacking_q <= 1'b0;
         exec_one_q <= 1'b0;
         stack_q <= 1'b0;
         go_q <= 1'b0;
         done_q <= 1'b0;
         refused_q <= 1'b0;
         sbrk_q <= 1'b0;
         free_run_q <= 1'b1;
      end
      else
      begin
         state_q <= state_d;
         pc_q <= pc_d;
         stacking_q <= stacking_d;
         exec_one_q <= exec_one_d;
         stack_q <= stack_d;
         go_q <= go_d;
         done_q <= done_d;
         refused_q <= refused_d;
         sbrk_q <= sbrk_d;
         free_run_q <= free_run_d;
      end
   end

   // Handshake side
   assign ack_if.ack_req = ack_req;
   assign ack_if.hs_set = hs_set;
   assign ack_if.hs_clr = hs_clr;
   assign ack_if.sys_stop = system_stop_in;

   dbss_ack_gen u_ack (
      .clk_sys_in (clk_sys_in),
      .rst_in (rst_in),
      .ack_if (ack_if),
      .ack_pulse_out (ack_pulse_out)
   );

   // Outputs, all from flip-flops
   assign core_exec_one_out = exec_one_q;
   assign core_stack_irq_out = stack_q;
   assign core_go_out = go_q;
   assign debug_active_out = (state_q == ST_ACTIVE);
   assign periph_free_run_out = free_run_q;
   assign saved_pc_out = pc_q;
   assign cmd_done_out = done_q;
   assign cmd_refused_out = refused_q;
   assign hs_enabled_out = ack_if.hs_en;
   assign soft_break_step_out = sbrk_q;

   sequence s_step_irq;
      state_q == ST_ACTIVE && cmd_valid_in && cmd_kind_in == CMD_STEP &&
      !system_stop_in && irq_pending_in;
   endsequence
   sequence s_step_plain;
      state_q == ST_ACTIVE && cmd_valid_in && cmd_kind_in == CMD_STEP &&
      !system_stop_in && !irq_pending_in;
   endsequence
   sequence s_wake;
      state_q == ST_LOWPWR && !core_lowpwr_in;
   endsequence
   property p_irq_no_exec;
      @(posedge clk_sys_in) disable iff (rst_in)
      s_step_irq |=> core_stack_irq_out && !core_exec_one_out;
   endproperty
   a_irq_no_exec: assert property (p_irq_no_exec)
      else $error("interrupt step executed a user instruction");
   property p_irq_pc;
      @(posedge clk_sys_in) disable iff (rst_in)
      state_q == ST_STEP && stacking_q && !core_lowpwr_in &&
      core_step_done_in |=> saved_pc_out == $past(irq_vector_in) &&
      debug_active_out;
   endproperty
   a_irq_pc: assert property (p_irq_pc)
      else $error("stacking step left wrong PC");
   property p_free_run;
      @(posedge clk_sys_in) disable iff (rst_in)
      !debug_active_out |-> periph_free_run_out;
   endproperty
   a_free_run: assert property (p_free_run)
      else $error("peripherals halted during step");
   property p_lowpwr_holds;
      @(posedge clk_sys_in) disable iff (rst_in)
      state_q == ST_STEP && core_lowpwr_in |=> !debug_active_out && !cmd_done_out;
   endproperty
   a_lowpwr_holds: assert property (p_lowpwr_holds)
      else $error("step completed while in low power");
   property p_lp_force_refused;
      @(posedge clk_sys_in) disable iff (rst_in)
      state_q == ST_LOWPWR && core_lowpwr_in && cmd_valid_in &&
      cmd_kind_in == CMD_FORCE_ACT |=> cmd_refused_out && !debug_active_out;
   endproperty
   a_lp_force_refused: assert property (p_lp_force_refused)
      else $error("force-active taken in stepped low power");
   property p_lp_hw_taken;
      @(posedge clk_sys_in) disable iff (rst_in)
      state_q == ST_LOWPWR && cmd_valid_in && cmd_kind_in == CMD_HW &&
      !system_stop_in |=> cmd_done_out;
   endproperty
   a_lp_hw_taken: assert property (p_lp_hw_taken)
      else $error("hardware command refused in low power");
   property p_sys_stop;
      @(posedge clk_sys_in) disable iff (rst_in)
      system_stop_in && cmd_valid_in |=> cmd_refused_out && !core_go_out;
   endproperty
   a_sys_stop: assert property (p_sys_stop)
      else $error("command executed in system stop");
   property p_wake;
      @(posedge clk_sys_in) disable iff (rst_in)
      s_wake |=> debug_active_out && saved_pc_out == $past(irq_vector_in);
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake did not enter active mode at vector");
   // Second cycle may carry the ack of a command taken right after wake
   property p_wake_no_ack;
      @(posedge clk_sys_in) disable iff (rst_in)
      s_wake and (!ack_if.ack_busy && !(cmd_valid_in && accept))
      |=> !ack_pulse_out ##1 (!ack_pulse_out || $past(accept));
   endproperty
   a_wake_no_ack: assert property (p_wake_no_ack)
      else $error("acknowledge sent for low-power step");
   property p_plain_step;
      @(posedge clk_sys_in) disable iff (rst_in)
      s_step_plain |=> core_exec_one_out && !core_stack_irq_out ##1
      !core_exec_one_out;
   endproperty
   a_plain_step: assert property (p_plain_step)
      else $error("plain step did not issue exactly one instruction");
endmodule
`default_nettype wire

// ---- dv/dbss_core_model.sv ----
// Stand-in for the core behind the step sequencer.
// Assumes step and stacking requests are one-cycle pulses on clk_sys_in.
`timescale 1ns/1ps
`default_nettype none
module dbss_core_model
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic exec_one_in,
   input wire logic stack_irq_in,
   input wire logic stop_next_in,
   output logic step_done_out,
   output logic lowpwr_out,
   output logic [15:0] pc_out
);
   logic [2:0] dly_q;
   logic [5:0] sleep_q;

   // Sleeps while the stop counter runs; a wake needs no host action
   assign lowpwr_out = (sleep_q != 6'h00);

   // Answers slowly: done three cycles late, so the sequencer must wait
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         dly_q <= 3'h0;
         sleep_q <= 6'h00;
         step_done_out <= 1'b0;
         pc_out <= 16'h0100;
      end
      else
      begin
         step_done_out <= (dly_q == 3'h1);
         if (dly_q != 3'h0)
            dly_q <= dly_q - 3'h1;
         if (sleep_q != 6'h00)
            sleep_q <= sleep_q - 6'h01;
         if (exec_one_in)
            pc_out <= pc_out + 16'h0002;
         // A stepped stop never reports done, only the sleep
         if (exec_one_in && stop_next_in)
            sleep_q <= 6'h28;
         else if (exec_one_in || stack_irq_in)
            dly_q <= 3'h3;
      end
   end
endmodule
`default_nettype wire

// ---- dv/dbss_step_ctrl_bench.sv ----
// Self-checking bench for the single-step sequencer.
// Assumes dbss_core_model answers the core side.
`timescale 1ns/1ps
`default_nettype none
module dbss_step_ctrl_bench;
   import dbss_pkg::*;
   logic clk_sys_in;
   logic rst_in;
   logic cmd_valid_in;
   dbss_cmd_type cmd_kind_in;
   logic irq_pending_in;
   logic system_stop_in;
   logic stop_next;
   logic [15:0] core_pc;
   logic step_done;
   logic lowpwr;
   logic exec_one_out, stack_irq_out, go_out, active_out, periph_out;
   logic [15:0] saved_pc_out;
   logic done_out, refused_out, hs_out, soft_out, ack_out;
   int n_errors = 0;
   int cmp_count = 0;
   int n;

   // Free-running 25 MHz clock
   initial
   begin
      clk_sys_in = 1'b0;
      forever #20 clk_sys_in = ~clk_sys_in;
   end

   dbss_step_ctrl dut_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .cmd_valid_in(cmd_valid_in), .cmd_kind_in(cmd_kind_in),
      .irq_pending_in(irq_pending_in), .irq_vector_in(16'h4a00),
      .core_pc_in(core_pc), .core_step_done_in(step_done),
      .core_lowpwr_in(lowpwr), .system_stop_in(system_stop_in),
      .soft_break_instr_in(1'b0),
      .core_exec_one_out(exec_one_out), .core_stack_irq_out(stack_irq_out),
      .core_go_out(go_out), .debug_active_out(active_out),
      .periph_free_run_out(periph_out), .saved_pc_out(saved_pc_out),
      .cmd_done_out(done_out), .cmd_refused_out(refused_out),
      .hs_enabled_out(hs_out), .soft_break_step_out(soft_out),
      .ack_pulse_out(ack_out));

   dbss_core_model core_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .exec_one_in(exec_one_out), .stack_irq_in(stack_irq_out),
      .stop_next_in(stop_next), .step_done_out(step_done),
      .lowpwr_out(lowpwr), .pc_out(core_pc));

   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("MISMATCH %s exp %h seen %h", what, exp, seen);
      end
   endtask

   // Offer one command; returns just after the taking edge
   task automatic send(input dbss_cmd_type k);
      @(posedge clk_sys_in);
      cmd_valid_in <= 1'b1;
      cmd_kind_in <= k;
      @(posedge clk_sys_in);
      cmd_valid_in <= 1'b0;
      #1;
   endtask

   // Bounded wait for the end of a step
   task automatic wait_done();
      n = 0;
      while (done_out !== 1'b1 && n < 200)
      begin
         @(posedge clk_sys_in);
         #1;
         n++;
      end
      // A step that never ends is a failure in itself
      if (n >= 200)
         n_errors++;
   endtask

   // Counts how long the acknowledge stays high
   task automatic ack_len();
      n = 0;
      while (ack_out === 1'b1 && n < 40)
      begin
         @(posedge clk_sys_in);
         #1;
         n++;
      end
   endtask

   task automatic t_plain();
      send(CMD_STEP);
      chk("exec", exec_one_out, 1);
      chk("periph", periph_out, 1);
      chk("no sbrk", soft_out, 0);
      wait_done();
      chk("pc", saved_pc_out, 16'h0102);
      chk("active", active_out, 1);
      chk("ack off", ack_out, 0);
   endtask

   task automatic t_go_force();
      send(CMD_GO);
      chk("go", go_out, 1);
      chk("run", active_out, 0);
      send(CMD_FORCE_ACT);
      chk("forced", active_out, 1);
      chk("forced pc", saved_pc_out, 16'h0102);
   endtask

   task automatic t_irq();
      send(CMD_ACK_EN);
      chk("hs on", hs_out, 1);
      @(posedge clk_sys_in);
      irq_pending_in <= 1'b1;
      send(CMD_STEP);
      chk("stack", stack_irq_out, 1);
      chk("no exec", exec_one_out, 0);
      wait_done();
      irq_pending_in <= 1'b0;
      chk("isr pc", saved_pc_out, 16'h4a00);
      chk("ack", ack_out, 1);
      ack_len();
      chk("ack len", n, ACK_PULSE_CYC);
   endtask

   // Stepped stop: commands in low power, then silent wake
   task automatic t_stop();
      stop_next <= 1'b1;
      send(CMD_STEP);
      chk("stop exec", exec_one_out, 1);
      repeat (3) @(posedge clk_sys_in);
      #1;
      chk("no done", done_out, 0);
      chk("asleep", active_out, 0);
      send(CMD_HW);
      chk("hw done", done_out, 1);
      chk("hw ack", ack_out, 1);
      ack_len();
      chk("hw ack len", n, ACK_PULSE_CYC);
      send(CMD_FORCE_ACT);
      chk("force refused", refused_out, 1);
      send(CMD_FW);
      chk("fw refused", refused_out, 1);
      wait_done();
      chk("wake pc", saved_pc_out, 16'h4a00);
      chk("wake active", active_out, 1);
      chk("no ack", ack_out, 0);
      @(posedge clk_sys_in);
      #1;
      chk("no ack late", ack_out, 0);
      chk("hs kept", hs_out, 1);
      stop_next <= 1'b0;
   endtask

   task automatic t_sys_stop();
      @(posedge clk_sys_in);
      system_stop_in <= 1'b1;
      send(CMD_HW);
      chk("stop refused", refused_out, 1);
      chk("stop no done", done_out, 0);
      chk("hs cleared", hs_out, 0);
      system_stop_in <= 1'b0;
      send(CMD_ACK_EN);
      chk("hs again", hs_out, 1);
      send(CMD_ACK_DIS);
      chk("hs off", hs_out, 0);
      chk("dis ack", ack_out, 1);
   endtask

   task automatic test_done();
      if (n_errors == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Whole run is well under 1000 cycles
   initial
   begin
      repeat (5000) @(posedge clk_sys_in);
      n_errors++;
      test_done();
   end

   initial
   begin
      rst_in = 1'b1;
      cmd_valid_in = 1'b0;
      cmd_kind_in = CMD_HW;
      irq_pending_in = 1'b0;
      system_stop_in = 1'b0;
      stop_next = 1'b0;
      repeat (10) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      #1;
      chk("rst active", active_out, 1);
      chk("rst hs", hs_out, 0);
      chk("rst periph", periph_out, 1);
      t_plain();
      t_go_force();
      t_irq();
      t_stop();
      t_sys_stop();
      test_done();
   end
endmodule
`default_nettype wire
